// ==== design/drl_core.sv ====
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - While jog is active, the reference is the fixed jog frequency, default 10.0 Hz.
// - Jog from inputs or serial; panel jog only when local jog is enabled.
// - Combine code 0 sum, 1 relative, 2 external-or-setpoint switch; sum default.
// - Sum mode adds setpoint percent of reference span to external total.
// - Relative mode adds setpoint percent of the external total to it.
// - Switch mode picks external total or setpoint as percent of span.
// - External total is analogue, pulse and serial references summed.
// - In sum or relative mode one setpoint always contributes; zero has no effect.
// - Four signed setpoints, -100.00 to +100.00 percent, default zero.
// - Select bits msb,lsb 00..11 pick setpoint one to four.
// - Catch-up adds the trim percent to the remote reference.
// - Slow-down subtracts the same trim percent from the remote reference.
// - Remote reference is setpoint part plus analogue, pulse and serial references, in sum and relative modes.
// - Output current ceiling, percent of rated current, default 160 percent.
// - Low-current warning below threshold; threshold default 0, at most high threshold.
// - High-current warning above threshold; threshold at most maximum current.
// - Low-frequency warning below threshold; default 0, at most high threshold.
// - Warnings suppressed while ramping, stopping or stopped, until reference is reached.
// - Active warnings route as programmed to the signal terminal and relay.
// - High-frequency warning above threshold, default 132.0 Hz.
// - Combined reference never exceeds the maximum reference.
module drl_core #(
    parameter drl_pkg::drl_val_t CONVERTER_RATED_CURRENT = 32'sh0000_0064,
    parameter drl_pkg::drl_val_t FREQ_HIGH_LIMIT         = drl_pkg::F_MAX_DEF
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      din_jog,
    input  wire logic                      din_catch_up,
    input  wire logic                      din_slow_down,
    input  wire logic                      din_preset_lsb,
    input  wire logic                      din_preset_msb,
    input  wire logic                      din_preset_on,
    input  wire drl_pkg::drl_val_t         analog_ref_a,
    input  wire drl_pkg::drl_val_t         analog_ref_b,
    input  wire drl_pkg::drl_val_t         pulse_ref,
    input  wire drl_pkg::drl_val_t         output_freq,
    input  wire drl_pkg::drl_val_t         output_current,
    input  wire logic                      run_start,
    input  wire logic                      run_stop,
    input  wire logic                      update_tick,
    output drl_pkg::drl_val_t              freq_reference,
    output drl_pkg::drl_val_t              output_current_ceiling,
    output logic                           jog_active,
    output logic [drl_pkg::NWARN-1:0]      warn_flags,
    output logic                           warn_terminal,
    output logic                           warn_relay
);
    import drl_pkg::*;

    // ************************************************************
    // Derived limits
    // ************************************************************
    localparam drl_val_t IMAX = drl_sat32((64'(CONVERTER_RATED_CURRENT) * 64'(CEIL_DEF)) / 64'(PCT_FULL));

    drl_state_s s_q;
    drl_state_s s_d;

    drl_val_t   ext_total;
    drl_val_t   span;
    drl_val_t   preset_sel;
    drl_val_t   p_span;
    drl_val_t   p_rel;
    drl_val_t   remote;
    drl_val_t   trim_amt;
    drl_val_t   trimmed;
    drl_val_t   clamped;
    drl_val_t   ceil_amps;
    drl_val_t   next_ref;
    logic [1:0] func;
    logic [1:0] sel;
    logic       jog_req;
    logic       catch_on;
    logic       slow_on;
    logic       preset_on;
    logic       ap_write;
    logic       ap_setup;

    // ************************************************************
    // Reference path
    // ************************************************************
    assign func      = s_q.ctrl[CTL_FUNC_LSB +: 2];
    assign catch_on  = s_q.sync2[S_CATCH];
    assign slow_on   = s_q.sync2[S_SLOW];
    assign preset_on = s_q.sync2[S_PON] | s_q.ctrl[CTL_SER_PON];

    assign ext_total = drl_sat32(64'(analog_ref_a) + 64'(analog_ref_b) + 64'(pulse_ref) + 64'(s_q.ser_ref));

    // setpoint select from pins or serial.
    assign sel = {s_q.sync2[S_MSB] | s_q.ctrl[CTL_SER_MSB], s_q.sync2[S_LSB] | s_q.ctrl[CTL_SER_LSB]};
    assign preset_sel = s_q.preset[sel];
    assign span       = drl_sat32(64'(s_q.ref_max) - 64'(s_q.ref_min));

    drl_pct_scale u_span_scale (
        .base   (span),
        .pct    (preset_sel),
        .scaled (p_span)
    );

    drl_pct_scale u_rel_scale (
        .base   (ext_total),
        .pct    (preset_sel),
        .scaled (p_rel)
    );

    // combine mode select; an unused code behaves as sum.
    // sum adds span share. relative adds total share.
    // switch picks one source. setpoint always in for sum and relative.
    // remote reference is setpoint plus external total, except in switch mode.
    assign remote = (func == FUNC_REL) ? drl_sat32(64'(s_q.ref_min) + 64'(ext_total) + 64'(p_rel)) :
                    (func == FUNC_SWITCH) ?
                        (preset_on ? drl_sat32(64'(s_q.ref_min) + 64'(p_span))
                                   : drl_sat32(64'(s_q.ref_min) + 64'(ext_total))) :
                    drl_sat32(64'(s_q.ref_min) + 64'(ext_total) + 64'(p_span));

    drl_pct_scale u_trim_scale (
        .base   (remote),
        .pct    (s_q.trim),
        .scaled (trim_amt)
    );

    // catch-up adds trim. slow-down subtracts it.
    assign trimmed = drl_sat32(64'(remote) + (catch_on ? 64'(trim_amt) : 64'sh0)
                               - (slow_on ? 64'(trim_amt) : 64'sh0));

    // keep the total inside the reference range.
    assign clamped = drl_clamp(trimmed, s_q.ref_min, s_q.ref_max);

    // panel jog needs the local jog enable.
    assign jog_req = s_q.sync2[S_JOG] | s_q.ctrl[CTL_SER_JOG]
                   | (s_q.ctrl[CTL_PANEL_JOG] & s_q.ctrl[CTL_LOCAL_JOG]);

    assign next_ref = jog_req ? s_q.jog_freq : clamped;

    drl_pct_scale u_ceil_scale (
        .base   (CONVERTER_RATED_CURRENT),
        .pct    (s_q.ceil),
        .scaled (ceil_amps)
    );

    // ************************************************************
    // State update
    // ************************************************************
    assign ap_write = psel & penable & pwrite;
    assign ap_setup = psel & ~penable;

    always_comb begin
        s_d = s_q;
        // Pins are asynchronous; only the second stage is read.
        s_d.sync1 = {din_preset_on, din_preset_msb, din_preset_lsb, din_slow_down, din_catch_up, din_jog};
        s_d.sync2 = s_q.sync1;

        // warning gate follows start, stop and reference reached.
        case (s_q.gate)
            GATE_STOPPED: begin
                if (run_start) begin
                    s_d.gate = GATE_RAMP;
                end
            end
            GATE_RAMP: begin
                if (run_stop) begin
                    s_d.gate = GATE_STOPPED;
                end else if (update_tick && output_freq == s_q.result) begin
                    s_d.gate = GATE_REACHED;
                end
            end
            GATE_REACHED: begin
                if (run_stop) begin
                    s_d.gate = GATE_STOPPED;
                end else if (run_start) begin
                    s_d.gate = GATE_RAMP;
                end
            end
            default: begin
                s_d.gate = GATE_STOPPED;
            end
        endcase

        if (update_tick) begin
            s_d.result   = next_ref;
            s_d.jog      = jog_req;
            s_d.ceil_out = ceil_amps;
            s_d.warn[W_I_LO] = output_current < s_q.i_low;
            s_d.warn[W_I_HI] = output_current > s_q.i_high;
            s_d.warn[W_F_LO] = output_freq < s_q.f_low;
            s_d.warn[W_F_HI] = output_freq > s_q.f_high;
        end
        // flags drop while the gate is closed.
        if (s_d.gate != GATE_REACHED) begin
            s_d.warn = '0;
        end

        s_d.term  = |(s_q.warn & s_q.route[NWARN-1:0]);
        s_d.relay = |(s_q.warn & s_q.route[2*NWARN-1:NWARN]);

        // Writes clamp to the documented ranges so that the comparisons stay ordered.
        if (ap_write) begin
            case (paddr)
                A_CTRL:    s_d.ctrl    = pwdata[CTL_W-1:0];
                A_REF_MIN: s_d.ref_min = drl_clamp(pwdata, VAL_MIN64[31:0], s_q.ref_max);
                A_REF_MAX: s_d.ref_max = drl_clamp(pwdata, s_q.ref_min, VAL_MAX64[31:0]);
                // setpoints limited to plus or minus full scale.
                A_PRESET0: s_d.preset[0] = drl_clamp(pwdata, PCT_NEG, PCT_FULL);
                A_PRESET1: s_d.preset[1] = drl_clamp(pwdata, PCT_NEG, PCT_FULL);
                A_PRESET2: s_d.preset[2] = drl_clamp(pwdata, PCT_NEG, PCT_FULL);
                A_PRESET3: s_d.preset[3] = drl_clamp(pwdata, PCT_NEG, PCT_FULL);
                A_TRIM:    s_d.trim     = drl_clamp(pwdata, VAL_ZERO, PCT_FULL);
                A_JOG:     s_d.jog_freq = drl_clamp(pwdata, VAL_ZERO, FREQ_HIGH_LIMIT);
                A_CEIL:    s_d.ceil     = drl_clamp(pwdata, VAL_ZERO, VAL_MAX64[31:0]);
                // low current threshold bounded by high threshold.
                A_I_LOW:   s_d.i_low    = drl_clamp(pwdata, VAL_ZERO, s_q.i_high);
                // high current threshold bounded by maximum current.
                A_I_HIGH:  s_d.i_high   = drl_clamp(pwdata, s_q.i_low, IMAX);
                // low frequency threshold bounded by high threshold.
                A_F_LOW:   s_d.f_low    = drl_clamp(pwdata, VAL_ZERO, s_q.f_high);
                A_F_HIGH:  s_d.f_high   = drl_clamp(pwdata, s_q.f_low, VAL_MAX64[31:0]);
                A_SER_REF: s_d.ser_ref  = pwdata;
                A_ROUTE:   s_d.route    = pwdata[2*NWARN-1:0];
                default:   s_d.ser_ref  = s_q.ser_ref;
            endcase
        end

        // Read data and error are prepared in the setup cycle so that the access needs no wait.
        if (ap_setup) begin
            s_d.err   = 1'b0;
            s_d.rdata = '0;
            case (paddr)
                A_CTRL:     s_d.rdata = {{(32-CTL_W){1'b0}}, s_q.ctrl};
                A_REF_MIN:  s_d.rdata = s_q.ref_min;
                A_REF_MAX:  s_d.rdata = s_q.ref_max;
                A_PRESET0:  s_d.rdata = s_q.preset[0];
                A_PRESET1:  s_d.rdata = s_q.preset[1];
                A_PRESET2:  s_d.rdata = s_q.preset[2];
                A_PRESET3:  s_d.rdata = s_q.preset[3];
                A_TRIM:     s_d.rdata = s_q.trim;
                A_JOG:      s_d.rdata = s_q.jog_freq;
                A_CEIL:     s_d.rdata = s_q.ceil;
                A_I_LOW:    s_d.rdata = s_q.i_low;
                A_I_HIGH:   s_d.rdata = s_q.i_high;
                A_F_LOW:    s_d.rdata = s_q.f_low;
                A_F_HIGH:   s_d.rdata = s_q.f_high;
                A_SER_REF:  s_d.rdata = s_q.ser_ref;
                A_ROUTE:    s_d.rdata = {{(32-2*NWARN){1'b0}}, s_q.route};
                A_STATUS: begin
                    s_d.rdata[NWARN-1:0] = s_q.warn;
                    s_d.rdata[ST_REACHED] = (s_q.gate == GATE_REACHED);
                    s_d.rdata[ST_JOG]     = s_q.jog;
                    s_d.err = pwrite;
                end
                A_RESULT: begin
                    s_d.rdata = s_q.result;
                    s_d.err   = pwrite;
                end
                A_CEIL_OUT: begin
                    s_d.rdata = s_q.ceil_out;
                    s_d.err   = pwrite;
                end
                default:    s_d.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q          <= '0;
            s_q.ref_max  <= REF_MAX_DEF;
            s_q.jog_freq <= JOG_DEF;
            s_q.ceil     <= CEIL_DEF;
            s_q.i_high   <= IMAX;
            s_q.f_high   <= F_HIGH_DEF;
            s_q.gate     <= GATE_STOPPED;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign prdata                 = s_q.rdata;
    assign pready                 = 1'b1;
    assign pslverr                = psel & penable & s_q.err;
    assign freq_reference         = s_q.result;
    assign output_current_ceiling = s_q.ceil_out;
    assign jog_active             = s_q.jog;
    assign warn_flags             = s_q.warn;
    assign warn_terminal          = s_q.term;
    assign warn_relay             = s_q.relay;

    // ************************************************************
    // Checks
    // ************************************************************
    // jog frequency applied.
    jog_ref_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && jog_req |=> freq_reference == $past(s_q.jog_freq) && jog_active)
        else $error("Jog frequency not applied.");

    panel_jog_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && !s_q.ctrl[CTL_LOCAL_JOG] && !s_q.ctrl[CTL_SER_JOG] && !s_q.sync2[S_JOG]
        |=> !jog_active)
        else $error("Panel jog honoured without enable.");

    ref_clamp_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && !jog_req |=> freq_reference <= $past(s_q.ref_max))
        else $error("Reference above maximum.");

    warn_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        run_stop |=> warn_flags == '0 ##1 warn_flags == '0)
        else $error("Warning active after stop.");

    warn_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !update_tick && s_d.gate == GATE_REACHED |=> $stable(warn_flags))
        else $error("Warning changed between ticks.");

    cur_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && s_d.gate == GATE_REACHED && output_current > s_q.i_high |=> warn_flags[W_I_HI])
        else $error("High current warning missing.");

    cur_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && s_d.gate == GATE_REACHED && output_current < s_q.i_low |=> warn_flags[W_I_LO])
        else $error("Low current warning missing.");

    freq_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        update_tick && s_d.gate == GATE_REACHED && !(output_freq < s_q.f_low) |=> !warn_flags[W_F_LO])
        else $error("Low frequency warning spurious.");

    relay_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 warn_relay == |($past(warn_flags) & $past(s_q.route[2*NWARN-1:NWARN])))
        else $error("Relay routing mismatch.");

    // ceiling moves only on a tick.
    ceil_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
        !update_tick |=> $stable(output_current_ceiling))
        else $error("Current ceiling changed off tick.");

endmodule // drl_core

// ==== design/drl_pct_scale.sv ====
`timescale 1ns/1ps
module drl_pct_scale (
    input  wire drl_pkg::drl_val_t base,
    input  wire drl_pkg::drl_val_t pct,
    output drl_pkg::drl_val_t      scaled
);
    import drl_pkg::*;

    logic signed [63:0] prod;

    // A 64-bit product keeps full precision before the divide; saturation covers any overflow.
    assign prod   = (64'(base) * 64'(pct)) / 64'(PCT_FULL);
    assign scaled = drl_sat32(prod);

endmodule // drl_pct_scale

// ==== design/drl_pkg.sv ====
package drl_pkg;

    // ************************************************************
    // Value types and units
    // ************************************************************
    // Frequencies are in 0.01 Hz, currents in 0.1 A, percentages in 0.01 %.
    typedef logic signed [31:0] drl_val_t;

    localparam logic signed [63:0] VAL_MAX64 = 64'sh0000_0000_7FFF_FFFF;
    localparam logic signed [63:0] VAL_MIN64 = 64'shFFFF_FFFF_8000_0000;
    localparam drl_val_t           PCT_FULL  = 32'sh0000_2710;
    localparam drl_val_t           PCT_NEG   = 32'shFFFF_D8F0;
    localparam drl_val_t           VAL_ZERO  = 32'sh0000_0000;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] A_CTRL     = 8'h00;
    localparam logic [7:0] A_REF_MIN  = 8'h04;
    localparam logic [7:0] A_REF_MAX  = 8'h08;
    localparam logic [7:0] A_PRESET0  = 8'h0C;
    localparam logic [7:0] A_PRESET1  = 8'h10;
    localparam logic [7:0] A_PRESET2  = 8'h14;
    localparam logic [7:0] A_PRESET3  = 8'h18;
    localparam logic [7:0] A_TRIM     = 8'h1C;
    localparam logic [7:0] A_JOG      = 8'h20;
    localparam logic [7:0] A_CEIL     = 8'h24;
    localparam logic [7:0] A_I_LOW    = 8'h28;
    localparam logic [7:0] A_I_HIGH   = 8'h2C;
    localparam logic [7:0] A_F_LOW    = 8'h30;
    localparam logic [7:0] A_F_HIGH   = 8'h34;
    localparam logic [7:0] A_SER_REF  = 8'h38;
    localparam logic [7:0] A_ROUTE    = 8'h3C;
    localparam logic [7:0] A_STATUS   = 8'h40;
    localparam logic [7:0] A_RESULT   = 8'h44;
    localparam logic [7:0] A_CEIL_OUT = 8'h48;

    // ************************************************************
    // Field layouts
    // ************************************************************
    localparam int CTL_W         = 8;
    localparam int CTL_FUNC_LSB  = 0;
    localparam int CTL_LOCAL_JOG = 2;
    localparam int CTL_PANEL_JOG = 3;
    localparam int CTL_SER_JOG   = 4;
    localparam int CTL_SER_LSB   = 5;
    localparam int CTL_SER_MSB   = 6;
    localparam int CTL_SER_PON   = 7;

    localparam logic [1:0] FUNC_SUM    = 2'h0;
    localparam logic [1:0] FUNC_REL    = 2'h1;
    localparam logic [1:0] FUNC_SWITCH = 2'h2;

    localparam int NWARN  = 4;
    localparam int W_I_LO = 0;
    localparam int W_I_HI = 1;
    localparam int W_F_LO = 2;
    localparam int W_F_HI = 3;
    localparam int ST_REACHED = 4;
    localparam int ST_JOG     = 5;

    localparam int NSYNC   = 6;
    localparam int S_JOG   = 0;
    localparam int S_CATCH = 1;
    localparam int S_SLOW  = 2;
    localparam int S_LSB   = 3;
    localparam int S_MSB   = 4;
    localparam int S_PON   = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam drl_val_t JOG_DEF     = 32'sh0000_03E8;
    localparam drl_val_t CEIL_DEF    = 32'sh0000_3E80;
    localparam drl_val_t F_HIGH_DEF  = 32'sh0000_3390;
    localparam drl_val_t REF_MAX_DEF = 32'sh0000_1388;
    localparam drl_val_t F_MAX_DEF   = 32'sh0000_3390;

    typedef enum logic [1:0] {GATE_STOPPED, GATE_RAMP, GATE_REACHED} drl_gate_e;

    typedef struct packed {
        logic [CTL_W-1:0]     ctrl;
        drl_val_t             ref_min;
        drl_val_t             ref_max;
        drl_val_t [3:0]       preset;
        drl_val_t             trim;
        drl_val_t             jog_freq;
        drl_val_t             ceil;
        drl_val_t             i_low;
        drl_val_t             i_high;
        drl_val_t             f_low;
        drl_val_t             f_high;
        drl_val_t             ser_ref;
        logic [2*NWARN-1:0]   route;
        logic [NSYNC-1:0]     sync1;
        logic [NSYNC-1:0]     sync2;
        drl_gate_e            gate;
        drl_val_t             result;
        drl_val_t             ceil_out;
        logic [NWARN-1:0]     warn;
        logic                 term;
        logic                 relay;
        logic                 jog;
        drl_val_t             rdata;
        logic                 err;
    } drl_state_s;

    function automatic drl_val_t drl_sat32(input logic signed [63:0] v);
        if (v > VAL_MAX64) begin
            return VAL_MAX64[31:0];
        end else if (v < VAL_MIN64) begin
            return VAL_MIN64[31:0];
        end
        return v[31:0];
    endfunction

    function automatic drl_val_t drl_clamp(input drl_val_t v, input drl_val_t lo, input drl_val_t hi);
        if (v > hi) begin
            return hi;
        end else if (v < lo) begin
            return lo;
        end
        return v;
    endfunction

endpackage

// ==== test/drive_reference_and_limit_warnings_test.sv ====
`timescale 1ns/1ps
module drive_reference_and_limit_warnings_test;
    import drl_pkg::*;
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin fails++; \
    $display("mismatch %s exp %0d got %0d", n, e, v); end end
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err, pready, pslverr;
    logic run_start = 0, run_stop = 0, update_tick = 0, jog_active, warn_terminal, warn_relay;
    logic din_jog, din_catch_up, din_slow_down, din_preset_lsb, din_preset_msb, din_preset_on;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, s;
    logic [5:0] cmd = 0;
    logic [NWARN-1:0] warn_flags;
    drl_val_t analog_ref_a = 0, analog_ref_b = 0, pulse_ref = 0, output_freq = 0, output_current = 0;
    drl_val_t freq_reference, output_current_ceiling, q, sr, ex;
    logic [7:0] ra[5] = '{A_JOG, A_CEIL, A_F_HIGH, A_I_HIGH, A_PRESET3};
    drl_val_t rv[5] = '{JOG_DEF, CEIL_DEF, F_HIGH_DEF, 160, 0};
    int fails = 0, n_checks = 0, seed = 34;
    drl_core dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .din_jog, .din_catch_up, .din_slow_down, .din_preset_lsb, .din_preset_msb, .din_preset_on,
        .analog_ref_a, .analog_ref_b, .pulse_ref, .output_freq, .output_current, .run_start, .run_stop,
        .update_tick, .freq_reference, .output_current_ceiling, .jog_active, .warn_flags, .warn_terminal, .warn_relay);
    drl_panel pnl (.pclk, .cmd, .din_jog, .din_catch_up, .din_slow_down, .din_preset_lsb, .din_preset_msb,
        .din_preset_on);
    initial forever #2.5 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        i = 0;
        do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 8);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin fails++; end_of_test; end
        @(posedge pclk);
    endtask
    task automatic tk;
        update_tick <= 1;
        @(posedge pclk);
        update_tick <= 0;
        @(posedge pclk);
    endtask
    // Mirrors the combine modes with a 10.00 to 50.00 Hz span; k is the signed trim.
    function automatic drl_val_t ref_of(input logic [1:0] fn, input drl_val_t e, input drl_val_t p,
                                        input logic on, input drl_val_t k);
        drl_val_t r;
        case (fn)
            2'h1: r = 1000 + e + e * p / 10000;
            2'h2: r = on ? 1000 + 4000 * p / 10000 : 1000 + e;
            default: r = 1000 + e + 4000 * p / 10000;
        endcase
        r = r + r * k / 10000;
        return (r > 5000) ? 5000 : ((r < 1000) ? 1000 : r);
    endfunction
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) begin
            apb(0, ra[i], 0);
            `CHK("reset value", rv[i], rd)
        end
        apb(0, 8'h4C, 0);
        `CHK("unmapped", 1'b1, err)
        apb(1, A_REF_MIN, 1000);
        apb(1, A_PRESET0, 1500);
        apb(1, A_TRIM, 1000);
        analog_ref_a <= 1600;
        for (int f = 0; f < 2; f++) begin
            apb(1, A_CTRL, f);
            tk;
            `CHK("example", f ? 2840 : 3200, freq_reference)
        end
        `CHK("ceiling", 160, output_current_ceiling)
        for (int i = 0; i < 12; i++) begin
            s = $random(seed);
            s[1:0] = 2'(i);
            q = $random(seed) % 10001;
            sr = $random(seed) % 1000;
            apb(1, A_CTRL, s[1:0]);
            apb(1, A_PRESET0 + {4'h0, s[3:2], 2'b00}, q);
            apb(1, A_SER_REF, sr);
            cmd <= {s[4], s[3], s[2], s[6], s[5], 1'b0};
            analog_ref_a <= $random(seed) % 1000;
            analog_ref_b <= $random(seed) % 1000;
            pulse_ref <= $random(seed) % 1000;
            repeat (4) @(posedge pclk);
            tk;
            ex = ref_of(s[1:0], analog_ref_a + analog_ref_b + pulse_ref + sr, q, s[4],
                        1000 * (int'(s[5]) - int'(s[6])));
            `CHK("reference", ex, freq_reference)
        end
        cmd <= 6'h01;
        output_current <= 200;
        output_freq <= 999;
        apb(1, A_ROUTE, 32'h22);
        repeat (4) @(posedge pclk);
        run_start <= 1;
        @(posedge pclk);
        run_start <= 0;
        tk;
        `CHK("jog", JOG_DEF, freq_reference)
        `CHK("jog active", 1'b1, jog_active)
        `CHK("gated", 4'h0, warn_flags)
        output_freq <= 1000;
        tk;
        `CHK("warnings", 4'h2, warn_flags)
        @(posedge pclk);
        `CHK("terminal", 1'b1, warn_terminal & warn_relay)
        run_stop <= 1;
        @(posedge pclk);
        run_stop <= 0;
        repeat (2) @(posedge pclk);
        `CHK("stopped", 4'h0, warn_flags)
        cmd <= 6'h00;
        for (int j = 0; j < 2; j++) begin
            apb(1, A_CTRL, j ? 32'h0C : 32'h08);
            repeat (2) @(posedge pclk);
            tk;
            `CHK("panel jog", 1'(j), jog_active)
        end
        end_of_test;
    end
    initial begin
        #200000;
        fails++;
        end_of_test;
    end
endmodule // drive_reference_and_limit_warnings_test

// ==== test/drl_panel.sv ====
`timescale 1ns/1ps
module drl_panel (
    input  wire logic       pclk,
    input  wire logic [5:0] cmd,
    output logic            din_jog,
    output logic            din_catch_up,
    output logic            din_slow_down,
    output logic            din_preset_lsb,
    output logic            din_preset_msb,
    output logic            din_preset_on
);
    logic [5:0] pins_q = 6'h00;
    always_ff @(posedge pclk) begin
        pins_q <= cmd;
    end
    assign {din_preset_on, din_preset_msb, din_preset_lsb, din_slow_down, din_catch_up, din_jog} = pins_q;
endmodule // drl_panel
